// ==== hw/smcg_ctrl.v ====
// Purpose: sleep-mode controller, clock gating and wake logic
// Assumes: core signals on sys_clk, wake events may be asynchronous
// Notes: power-down and power-save start-up delay is a fuse-selected count given as a port
`include "smcg_map.vh"
module smcg_ctrl #(
    parameter CNT_W = `SMCG_CNT_W
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // core side
    input wire sleep_instr,
    input wire sleep_arm_bit,
    input wire [2:0] sleep_mode_code,
    input wire global_irq_en,
    input wire [1:0] timer2_irq_mask,
    input wire [CNT_W-1:0] startup_cycles,
    input wire xtal_clock_option,
    output wire core_halt,
    output reg [2:0] sleep_state,
    output reg wake_irq,
    // module configuration
    input wire adc_enable,
    input wire acomp_enable,
    input wire acomp_uses_ref,
    input wire bod_fused_on,
    input wire wdt_enable,
    input wire timer2_enable,
    input wire lcd_enable,
    input wire timer2_async,
    input wire lcd_async,
    input wire ext_irq_zero_level,
    // wake events, possibly asynchronous
    input wire ext_irq_zero,
    input wire pin_change_irq,
    input wire usi_start_irq,
    input wire lcd_irq,
    input wire timer2_ovf_irq,
    input wire timer2_cmp_irq,
    input wire adc_done_irq,
    input wire store_ready_irq,
    // clock enables
    output reg clk_cpu_en,
    output reg clk_flash_en,
    output reg clk_io_en,
    output reg clk_adc_en,
    output reg async_clock_domain_en,
    output reg main_osc_en,
    output reg timer_osc_en,
    output reg t2_lcd_sync_clk_en,
    // analog helpers
    output reg adc_start_conv,
    output reg adc_extended_conv,
    output reg acomp_power,
    output reg bod_active,
    output reg wdt_run,
    output reg vref_enable,
    output reg input_buf_en
);
    // ------------------------------------------------------------
    // wake inputs
    // ------------------------------------------------------------
    wire [7:0] ev_raw;
    wire [7:0] ev;
    wire [7:0] ev_hi;
    // int zero is inverted before the synchroniser, so the stage
    // reset value matches its idle level and no false wake follows reset
    assign ev_raw = {store_ready_irq, adc_done_irq, timer2_cmp_irq,
                     timer2_ovf_irq, lcd_irq, usi_start_irq,
                     pin_change_irq, ~ext_irq_zero};
    smcg_sync #(
        .W(8)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(ev_raw),
        .sync_out(ev)
    );
    // all wake events now active high
    assign ev_hi = ev;
    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    reg [2:0] mode_reg;
    reg [2:0] mode_next;
    reg [CNT_W-1:0] cnt_reg;
    reg [CNT_W-1:0] cnt_next;
    reg [2:0] state_next;
    reg adc_was_on_reg;
    reg wake_any;
    wire valid_code;
    wire deep;
    assign valid_code = (sleep_mode_code == `SMCG_MODE_IDLE) ||
                        (sleep_mode_code == `SMCG_MODE_ADCNR) ||
                        (sleep_mode_code == `SMCG_MODE_PDOWN) ||
                        (sleep_mode_code == `SMCG_MODE_PSAVE) ||
                        ((sleep_mode_code == `SMCG_MODE_STBY) &&
                         xtal_clock_option);
    assign deep = (sleep_state != `SMCG_ST_RUN) &&
                  (mode_reg != `SMCG_MODE_IDLE) &&
                  (mode_reg != `SMCG_MODE_ADCNR);
    // ------------------------------------------------------------
    // wake source selection per mode
    // ------------------------------------------------------------
    // int zero only as level in every mode except idle
    wire ext_irq_zero_wake;
    wire t2_wake;
    assign ext_irq_zero_wake = ext_irq_zero_level & ev_hi[0];
    assign t2_wake = global_irq_en &
                     ((timer2_irq_mask[0] & ev_hi[4]) |
                      (timer2_irq_mask[1] & ev_hi[5]));
    always @* begin
        wake_any = 1'b0;
        case (mode_reg)
            `SMCG_MODE_IDLE: begin
                wake_any = |ev_hi;
            end
            `SMCG_MODE_ADCNR: begin
                wake_any = ext_irq_zero_wake | ev_hi[1] | ev_hi[2] |
                           ev_hi[3] | ev_hi[4] | ev_hi[5] |
                           ev_hi[6] | ev_hi[7];
            end
            `SMCG_MODE_PDOWN, `SMCG_MODE_STBY: begin
                wake_any = ext_irq_zero_wake | ev_hi[1] | ev_hi[2];
            end
            `SMCG_MODE_PSAVE: begin
                wake_any = ext_irq_zero_wake | ev_hi[1] | ev_hi[2] |
                           ev_hi[3] | t2_wake;
            end
            default: begin
                wake_any = 1'b0;
            end
        endcase
    end
    // ------------------------------------------------------------
    // sleep sequencer
    // ------------------------------------------------------------
    // resets during sleep come in on rst_n and restart the core
    always @* begin
        state_next = sleep_state;
        mode_next = mode_reg;
        cnt_next = cnt_reg;
        case (sleep_state)
            `SMCG_ST_RUN: begin
                if (sleep_instr && sleep_arm_bit && valid_code) begin
                    state_next = `SMCG_ST_SLEEP;
                    mode_next = sleep_mode_code;
                end
            end
            `SMCG_ST_SLEEP: begin
                // level must persist through the synchroniser
                if (wake_any) begin
                    state_next = `SMCG_ST_START;
                    // standby wakes in six cycles
                    // start-up spans count plus one, so load one less
                    if (mode_reg == `SMCG_MODE_STBY) begin
                        cnt_next = {{(CNT_W-4){1'b0}},
                                    `SMCG_STBY_WAKE_CYC - 4'h1};
                    end else if ((mode_reg == `SMCG_MODE_PDOWN) ||
                                 (mode_reg == `SMCG_MODE_PSAVE)) begin
                        cnt_next = startup_cycles;
                    end else begin
                        cnt_next = {CNT_W{1'b0}};
                    end
                end
            end
            `SMCG_ST_START: begin
                if (cnt_reg == {CNT_W{1'b0}}) begin
                    state_next = `SMCG_ST_HALT;
                    cnt_next = {{(CNT_W-4){1'b0}}, `SMCG_HALT_CYC};
                end else begin
                    cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            `SMCG_ST_HALT: begin
                if (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    state_next = `SMCG_ST_RUN;
                    mode_next = `SMCG_MODE_IDLE;
                end
                cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
            end
            default: begin
                state_next = `SMCG_ST_RUN;
            end
        endcase
    end
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_state <= `SMCG_ST_RUN;
            mode_reg <= `SMCG_MODE_IDLE;
            cnt_reg <= {CNT_W{1'b0}};
            wake_irq <= 1'b0;
        end else begin
            sleep_state <= state_next;
            mode_reg <= mode_next;
            cnt_reg <= cnt_next;
            // one-cycle pulse: core now services the interrupt
            wake_irq <= (sleep_state == `SMCG_ST_HALT) &&
                        (state_next == `SMCG_ST_RUN);
        end
    end
    // core held until halt cycles are done
    assign core_halt = (sleep_state != `SMCG_ST_RUN);
    // ------------------------------------------------------------
    // clock gating and analog helpers
    // ------------------------------------------------------------
    wire asleep;
    wire osc_off;
    wire in_psave;
    wire io_stop;
    wire adc_stop;
    assign asleep = (sleep_state == `SMCG_ST_SLEEP);
    // during start-up the oscillator is running again
    assign in_psave = asleep && (mode_reg == `SMCG_MODE_PSAVE);
    assign io_stop = asleep && (mode_reg != `SMCG_MODE_IDLE);
    assign adc_stop = asleep && (mode_reg != `SMCG_MODE_IDLE) &&
                      (mode_reg != `SMCG_MODE_ADCNR);
    assign osc_off = asleep && ((mode_reg == `SMCG_MODE_PDOWN) ||
        ((mode_reg == `SMCG_MODE_PSAVE) &&
         !((timer2_enable && !timer2_async) ||
           (lcd_enable && !lcd_async))));
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_cpu_en <= 1'b1;
            clk_flash_en <= 1'b1;
            clk_io_en <= 1'b1;
            clk_adc_en <= 1'b1;
            async_clock_domain_en <= 1'b1;
            main_osc_en <= 1'b1;
            timer_osc_en <= 1'b1;
            t2_lcd_sync_clk_en <= 1'b1;
            input_buf_en <= 1'b1;
        end else begin
            // idle halts only cpu and flash
            clk_cpu_en <= !core_halt;
            clk_flash_en <= !core_halt;
            clk_io_en <= !io_stop;
            clk_adc_en <= !adc_stop;
            // each module picks its own source
            async_clock_domain_en <= !adc_stop || in_psave;
            main_osc_en <= !osc_off;
            // timer oscillator off in power-down and standby, and in power-save with no async user
            timer_osc_en <= !(in_psave &&
                !((timer2_enable && timer2_async) ||
                  (lcd_enable && lcd_async))) &&
                !(asleep && ((mode_reg == `SMCG_MODE_PDOWN) ||
                             (mode_reg == `SMCG_MODE_STBY)));
            // sync clock only for timer2 and lcd
            t2_lcd_sync_clk_en <= !adc_stop ||
                (in_psave && !osc_off);
            // buffers off when io and adc clocks stop
            // wake detection pins keep their own buffers
            input_buf_en <= !(io_stop && adc_stop);
        end
    end
    // analog helper enables; the adc itself is never gated here
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_start_conv <= 1'b0;
            adc_extended_conv <= 1'b1;
            adc_was_on_reg <= 1'b0;
            acomp_power <= 1'b0;
            bod_active <= 1'b0;
            wdt_run <= 1'b0;
            vref_enable <= 1'b0;
        end else begin
            // one conversion on noise reduction entry
            adc_start_conv <= adc_enable &&
                (sleep_state == `SMCG_ST_RUN) &&
                (state_next == `SMCG_ST_SLEEP) &&
                (mode_next == `SMCG_MODE_ADCNR);
            adc_was_on_reg <= adc_enable;
            if (adc_enable && !adc_was_on_reg) begin
                adc_extended_conv <= 1'b1;
            end else if (adc_start_conv) begin
                adc_extended_conv <= 1'b0;
            end
            // comparator off in deep sleep unless it uses the reference
            acomp_power <= acomp_enable &&
                (!deep || acomp_uses_ref);
            bod_active <= bod_fused_on;
            wdt_run <= wdt_enable;
            vref_enable <= bod_fused_on || adc_enable ||
                (acomp_enable && acomp_uses_ref &&
                 (!deep || acomp_uses_ref));
        end
    end
endmodule

// ==== common/smcg_map.vh ====
`ifndef SMCG_MAP_VH
`define SMCG_MAP_VH
// Purpose: constants of the sleep-mode clock gating block
// Assumes: 50 MHz sys_clk
// Notes: mode codes and timing counts
`define SMCG_MODE_IDLE 3'h0
`define SMCG_MODE_ADCNR 3'h1
`define SMCG_MODE_PDOWN 3'h2
`define SMCG_MODE_PSAVE 3'h3
`define SMCG_MODE_STBY 3'h6
`define SMCG_ST_RUN 3'h0
`define SMCG_ST_SLEEP 3'h1
`define SMCG_ST_START 3'h2
`define SMCG_ST_HALT 3'h3
`define SMCG_STBY_WAKE_CYC 4'h6
`define SMCG_HALT_CYC 4'h4
`define SMCG_CNT_W 16
`endif

// ==== hw/smcg_sync.v ====
// Purpose: three-stage input synchroniser for all eight wake events
// Assumes: one sys_clk domain
// Notes: output changes once stages two and three agree
module smcg_sync #(
    parameter W = 8
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // data
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    genvar i;
    // stage one feeds only stage two
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // per bit: accept a change once two stages agree
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync_out[i] <= 1'b0;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    sync_out[i] <= s3_reg[i];
                end
            end
        end
    endgenerate
endmodule

// ==== bench/smcg_props.sv ====
// Purpose: concurrent checks on the sleep-mode controller ports
// Assumes: one clock domain, reset active low
// Notes: bound into every smcg_ctrl instance
module smcg_props (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // core side
    input wire sleep_instr,
    input wire sleep_arm_bit,
    input wire [2:0] sleep_mode_code,
    input wire core_halt,
    input wire [2:0] sleep_state,
    input wire wake_irq,
    // clocks and helpers
    input wire clk_cpu_en,
    input wire clk_flash_en,
    input wire adc_enable,
    input wire acomp_enable,
    input wire bod_fused_on,
    input wire wdt_enable,
    input wire bod_active,
    input wire wdt_run,
    input wire vref_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------
    // checks
    // --------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    enter_sleep_a:
        assert property (sleep_instr && sleep_arm_bit && sleep_state == 3'h0
            && sleep_mode_code == 3'h2 |=> sleep_state == 3'h1 && core_halt)
        else $error("power-down request not taken");
    arm_needed_a:
        assert property (sleep_instr && !sleep_arm_bit && sleep_state == 3'h0
            |=> sleep_state == 3'h0) else $error("sleep taken without arm");
    reserved_nop_a:
        assert property (sleep_instr && sleep_state == 3'h0 &&
            (sleep_mode_code == 3'h4 || sleep_mode_code == 3'h5 ||
            sleep_mode_code == 3'h7) |=> sleep_state == 3'h0 && clk_cpu_en)
        else $error("reserved code changed state");
    // halt phase must be exactly four cycles long
    halt_four_a:
        assert property ($rose(sleep_state == 3'h3) |-> (sleep_state == 3'h3)
            [*4] ##1 (sleep_state == 3'h0 && wake_irq))
        else $error("halt phase length wrong");
    gated_core_a:
        assert property (sleep_state == 3'h1 && $past(sleep_state) == 3'h1
            |-> !clk_cpu_en && !clk_flash_en) else $error("core clock on");
    // clock enables lag the state by one cycle after resume
    run_clocks_a:
        assert property (sleep_state == 3'h0 && $past(sleep_state) == 3'h0
            |-> clk_cpu_en && clk_flash_en)
        else $error("core clock off while running");
    // first cycle must be out of reset, or the outputs still hold reset
    wdt_keep_a:
        assert property ((wdt_enable && rst_n) ##1 wdt_enable |-> wdt_run)
        else $error("watchdog stopped");
    bod_keep_a:
        assert property ((bod_fused_on && rst_n) ##1 bod_fused_on
            |-> bod_active) else $error("brown-out detector stopped");
    vref_off_a:
        assert property ((!bod_fused_on && !acomp_enable && !adc_enable &&
            rst_n) ##1 (!bod_fused_on && !acomp_enable && !adc_enable)
            |-> !vref_enable) else $error("reference on without user");
    // main scenarios reached
    cover property (sleep_state == 3'h2 ##1 sleep_state == 3'h3);
    cover property (wake_irq);
    cover property (sleep_instr && !sleep_arm_bit);
endmodule

bind smcg_ctrl smcg_props smcg_props_u (.sys_clk, .rst_n, .sleep_instr,
    .sleep_arm_bit, .sleep_mode_code, .core_halt, .sleep_state, .wake_irq,
    .clk_cpu_en, .clk_flash_en, .adc_enable, .acomp_enable, .bod_fused_on,
    .wdt_enable, .bod_active, .wdt_run, .vref_enable);

// ==== bench/smcg_core_model.sv ====
// Purpose: core-side model that issues the sleep instruction
// Assumes: bench requests arrive as levels on go, arm and mode
// Notes: the sleep pulse lasts one cycle, as a real instruction does
module smcg_core_model (
    // clock
    input wire sys_clk,
    // requests from the bench
    input wire go,
    input wire arm,
    input wire [2:0] mode,
    // core-side outputs
    output reg sleep_instr = 1'b0,
    output reg sleep_arm_bit = 1'b0,
    output reg [2:0] sleep_mode_code = 3'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // arm with sleep
    // arm is registered with the pulse, so the controller sees both together
    always @(posedge sys_clk) begin
        sleep_instr <= go;
        sleep_arm_bit <= arm;
        sleep_mode_code <= mode;
    end
endmodule

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for the sleep-mode controller
// Assumes: start-up count of 3, timer2 on the asynchronous clock
// Notes: wake events are held until the core resumes
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------
    // stimulus and outputs
    // --------------------------
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg go = 1'b0;
    reg arm = 1'b1;
    reg [2:0] mode = 3'h0;
    reg global_irq_en = 1'b0, xtal_clock_option = 1'b1, adc_enable = 1'b1;
    reg acomp_enable = 1'b1, acomp_uses_ref = 1'b0, bod_fused_on = 1'b1;
    reg wdt_enable = 1'b1, timer2_enable = 1'b1, lcd_enable = 1'b0;
    reg timer2_async = 1'b1, lcd_async = 1'b0, ext_irq_zero_level = 1'b1;
    reg ext_irq_zero = 1'b1;
    reg [1:0] timer2_irq_mask = 2'h2;
    reg [15:0] startup_cycles = 16'h0003;
    reg [6:0] ev = 7'h00;
    wire sleep_instr, sleep_arm_bit, core_halt, wake_irq;
    wire [2:0] sleep_mode_code, sleep_state;
    wire clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, main_osc_en;
    wire async_clock_domain_en, timer_osc_en, t2_lcd_sync_clk_en;
    wire adc_start_conv, adc_extended_conv, acomp_power, bod_active;
    wire wdt_run, vref_enable, input_buf_en;
    wire [6:0] clk_vec = {clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en,
        async_clock_domain_en, main_osc_en, timer_osc_en};
    wire [2:0] osc_vec = {main_osc_en, timer_osc_en, t2_lcd_sync_clk_en};
    integer n_mismatch = 0, checks = 0, n_conv = 0, k, n;
    // per mode: code, clock enables, wake event, start-up length
    logic [2:0] mt [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
    logic [6:0] et [5] = '{7'h1f, 7'h0f, 7'h00, 7'h05, 7'h02};
    logic [6:0] wt [5] = '{7'h40, 7'h20, 7'h01, 7'h02, 7'h01};
    integer st [5] = '{1, 1, 4, 4, 6};
    smcg_core_model core_u (.sys_clk, .go, .arm, .mode, .sleep_instr,
        .sleep_arm_bit, .sleep_mode_code);
    smcg_ctrl dut_u (.sys_clk, .rst_n, .sleep_instr, .sleep_arm_bit,
        .sleep_mode_code, .global_irq_en, .timer2_irq_mask, .startup_cycles,
        .xtal_clock_option, .core_halt, .sleep_state, .wake_irq, .adc_enable,
        .acomp_enable, .acomp_uses_ref, .bod_fused_on, .wdt_enable,
        .timer2_enable, .lcd_enable, .timer2_async, .lcd_async,
        .ext_irq_zero_level, .ext_irq_zero, .pin_change_irq(ev[0]),
        .usi_start_irq(ev[1]), .lcd_irq(ev[2]), .timer2_ovf_irq(ev[3]),
        .timer2_cmp_irq(ev[4]), .adc_done_irq(ev[5]),
        .store_ready_irq(ev[6]), .clk_cpu_en, .clk_flash_en, .clk_io_en,
        .clk_adc_en, .async_clock_domain_en, .main_osc_en, .timer_osc_en,
        .t2_lcd_sync_clk_en, .adc_start_conv, .adc_extended_conv,
        .acomp_power, .bod_active, .wdt_run, .vref_enable, .input_buf_en);
    // clock and conversion counter
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (adc_start_conv === 1'b1) n_conv <= n_conv + 1;
    // --------------------------
    // tasks
    // --------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        checks = checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD t=%0t %s got %0h exp %0h", $time, s, got, exp);
        end
    endtask
    // samples just after the edge so its updates have landed
    task tick(input integer c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task slp(input logic [2:0] m, input logic a);
        @(posedge sys_clk);
        go <= 1'b1;
        mode <= m;
        arm <= a;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask
    task len(input logic [2:0] s);
        n = 0;
        while (sleep_state === s && n < 500) begin
            tick(1);
            n = n + 1;
        end
    endtask
    task nop(input logic [2:0] m, input logic a);
        slp(m, a);
        tick(4);
        chk(sleep_state, 0, "refused sleep");
    endtask
    task blk(input logic [2:0] m, input logic [6:0] e);
        slp(m, 1'b1);
        tick(3);
        @(posedge sys_clk);
        ev <= e;
        tick(12);
        chk(sleep_state, 1, "wake blocked");
    endtask
    // event stays up until resume, longer than the synchroniser needs
    task wake(input logic [6:0] e, input logic [31:0] sl);
        @(posedge sys_clk);
        ev <= e;
        // look past the edge, so an immediate wake is seen settled
        #1;
        n = 0;
        while (sleep_state !== 3'h2 && n < 200) begin
            tick(1);
            n = n + 1;
        end
        len(3'h2);
        chk(n, sl, "start-up length");
        len(3'h3);
        chk(n, 4, "halt length");
        chk(wake_irq, 1, "resume flag");
        @(posedge sys_clk);
        ev <= 7'h00;
        ext_irq_zero <= 1'b1;
        // let the released level clear the synchroniser first
        tick(6);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // --------------------------
    // sequence
    // --------------------------
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        chk(adc_extended_conv, 1, "extended after reset");
        nop(3'h2, 1'b0);
        for (k = 4; k < 8; k = k + 1) if (k != 6) nop(k[2:0], 1'b1);
        @(posedge sys_clk);
        xtal_clock_option <= 1'b0;
        nop(3'h6, 1'b1);
        @(posedge sys_clk);
        xtal_clock_option <= 1'b1;
        for (k = 0; k < 5; k = k + 1) begin
            slp(mt[k], 1'b1);
            tick(3);
            chk(clk_vec, et[k], "clock enables");
            chk(input_buf_en, k < 2, "input buffers");
            chk(acomp_power, k < 2, "comparator power");
            wake(wt[k], st[k]);
        end
        @(posedge sys_clk);
        lcd_enable <= 1'b1;
        slp(3'h3, 1'b1);
        tick(3);
        chk(osc_vec, 3'h7, "mixed sources");
        wake(7'h04, 4);
        @(posedge sys_clk);
        lcd_enable <= 1'b0;
        chk(n_conv, 1, "auto conversions");
        chk(adc_extended_conv, 0, "normal conversion next");
        blk(3'h3, 7'h10);
        @(posedge sys_clk);
        global_irq_en <= 1'b1;
        wake(7'h10, 4);
        blk(3'h2, 7'h20);
        wake(7'h01, 4);
        @(posedge sys_clk);
        ext_irq_zero_level <= 1'b0;
        ext_irq_zero <= 1'b0;
        blk(3'h2, 7'h00);
        @(posedge sys_clk);
        ext_irq_zero_level <= 1'b1;
        wake(7'h00, 4);
        slp(3'h2, 1'b1);
        tick(3);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        tick(1);
        chk(sleep_state, 0, "reset in sleep");
        chk(clk_vec, 7'h7f, "clocks after reset");
        @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(2);
        @(posedge sys_clk);
        adc_enable <= 1'b0;
        acomp_enable <= 1'b0;
        bod_fused_on <= 1'b0;
        wdt_enable <= 1'b0;
        tick(3);
        chk(vref_enable, 0, "reference unused");
        chk(wdt_run, 0, "watchdog off");
        @(posedge sys_clk);
        adc_enable <= 1'b1;
        tick(3);
        chk(vref_enable, 1, "reference for converter");
        chk(adc_extended_conv, 1, "extended after re-enable");
        give_verdict;
    end
    // run needs well under a thousand cycles; ten thousand means a hang
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end
endmodule
